// File: eqs_search_ctrl.sv
// eqs_search_ctrl: adaptive receive equalizer search and hold control.
// assumes lock and register strobes are synchronous to clk_sys.
//
// Behaviour
// - wait dwell per setting, then check lock
// - on lock, hold setting while lock stays
// - on lock loss, advance gain and search
// - search runs freely from power-on
// - restart bit restarts search at any time
// - floor field sets each pass start gain
// - floor used only with override and apply
// - ceiling fixed at maximum gain code
// - reached setting readable in status register
// - dwell set by relock field, 2.62 ms default
// - no lock at maximum wraps to start
`timescale 1ns/1ps
module eqs_search_ctrl
    import eqs_pkg::*;
#(
    parameter int DWELL_UNIT_CYC = EQS_DWELL_UNIT_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic digital_soft_reset,
    input wire logic cdr_lock,
    output logic [EQS_GAIN_W-1:0] eq_gain,
    output logic eq_locked
);

    // refuse dwell units the counter cannot hold
    if (DWELL_UNIT_CYC < 1 || DWELL_UNIT_CYC * 8 >= (1 << EQS_CNT_W)) begin : g_chk
        $error("DWELL_UNIT_CYC out of range");
    end

    eqs_ctl1_t ctl1_q, ctl1_d;
    eqs_ctl2_t ctl2_q, ctl2_d;
    logic [7:0] rdata_q, rdata_d;
    logic restart_p;

    eqs_state_t state_q, state_d;
    logic [3:0] gain_q, gain_d;
    logic [EQS_CNT_W-1:0] cnt_q, cnt_d;
    logic [3:0] start_gain;
    logic [3:0] next_gain;
    logic [EQS_CNT_W-1:0] dwell_cyc;
    eqs_stat_t stat;

    // register writes, restart strobe and registered read data
    always_comb begin
        ctl1_d = ctl1_q;
        ctl2_d = ctl2_q;
        rdata_d = 8'h00;
        restart_p = digital_soft_reset;
        ctl1_d.equalizer_search_restart = 1'b0; // self clearing
        if (reg_wr && reg_addr == EQS_CTL1_ADDR) begin
            ctl1_d = eqs_ctl1_t'(reg_wdata);
            ctl1_d.equalizer_search_restart = 1'b0;
            restart_p = restart_p | reg_wdata[0];
        end else if (reg_wr && reg_addr == EQS_CTL2_ADDR) begin
            ctl2_d = eqs_ctl2_t'(reg_wdata);
        end
        if (reg_rd && reg_addr == EQS_CTL1_ADDR) begin
            rdata_d = ctl1_q;
        end else if (reg_rd && reg_addr == EQS_CTL2_ADDR) begin
            rdata_d = ctl2_q;
        end else if (reg_rd && reg_addr == EQS_STAT_ADDR) begin
            rdata_d = stat;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctl1_q <= eqs_ctl1_t'(EQS_CTL1_RST);
            ctl2_q <= eqs_ctl2_t'(EQS_CTL2_RST);
            rdata_q <= 8'h00;
        end else begin
            ctl1_q <= ctl1_d;
            ctl2_q <= ctl2_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // status view of the search
    always_comb begin
        stat = '0;
        stat.gain = gain_q;
        stat.locked = (state_q == EQS_HOLD);
    end

    // pass start: floor only when override and apply are both set; the incoming
    // write is used so that one write can set both enables and restart at the floor
    always_comb begin
        if (ctl1_d.floor_override_enable && ctl1_d.floor_apply_enable) begin
            start_gain = ctl2_d.gain_search_floor_level;
        end else begin
            start_gain = EQS_GAIN_MIN;
        end
    end

    // next candidate; the ceiling is a constant, wrap returns to start
    always_comb begin
        if (gain_q == EQS_GAIN_MAX) begin
            next_gain = start_gain;
        end else begin
            next_gain = gain_q + 4'h1;
        end
    end

    // dwell length in cycles from the relock field
    always_comb begin
        dwell_cyc = EQS_CNT_W'(DWELL_UNIT_CYC * (int'(ctl2_q.relock_dwell_time) + 1));
    end

    // search and hold state machine with dwell counter
    always_comb begin
        state_d = state_q;
        gain_d = gain_q;
        cnt_d = cnt_q;
        if (restart_p) begin
            state_d = EQS_SEARCH;
            gain_d = start_gain;
            cnt_d = dwell_cyc;
        end else begin
            case (state_q)
                EQS_SEARCH: begin
                    if (cnt_q != '0) begin
                        cnt_d = cnt_q - EQS_CNT_W'(1);
                    end else if (cdr_lock) begin
                        state_d = EQS_HOLD;
                    end else begin
                        gain_d = next_gain;
                        cnt_d = dwell_cyc;
                    end
                end
                EQS_HOLD: begin
                    if (!cdr_lock) begin
                        state_d = EQS_SEARCH;
                        gain_d = next_gain;
                        cnt_d = dwell_cyc;
                    end
                end
                default: begin
                    state_d = EQS_SEARCH;
                end
            endcase
        end
    end

    // search starts at minimum gain with default dwell out of reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= EQS_SEARCH;
            gain_q <= EQS_GAIN_MIN;
            cnt_q <= EQS_CNT_W'(DWELL_UNIT_CYC * (EQS_DWELL_DEF_CODE + 1));
        end else begin
            state_q <= state_d;
            gain_q <= gain_d;
            cnt_q <= cnt_d;
        end
    end

    assign eq_gain = gain_q;
    assign eq_locked = (state_q == EQS_HOLD);

    // helper for the free-run check: cycles spent on one dwell while searching
    logic [EQS_CNT_W-1:0] stall_q, stall_d;

    always_comb begin
        if (restart_p || state_q == EQS_HOLD || gain_d != gain_q || cnt_d > cnt_q) begin
            stall_d = '0;
        end else begin
            stall_d = stall_q + EQS_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stall_q <= '0;
        end else begin
            stall_q <= stall_d;
        end
    end

    // checks on the search behaviour
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    dwell_wait_a: assert property (
        state_q == EQS_SEARCH && cnt_q != '0 && !restart_p |=> $stable(gain_q) && state_q == EQS_SEARCH)
        else $error("gain moved before dwell ended");

    hold_steady_a: assert property (
        state_q == EQS_HOLD && cdr_lock && !restart_p |=> state_q == EQS_HOLD && $stable(gain_q))
        else $error("held gain changed while locked");

    lock_loss_a: assert property (
        state_q == EQS_HOLD && !cdr_lock && !restart_p
        |=> state_q == EQS_SEARCH && gain_q == $past(next_gain))
        else $error("search did not resume on lock loss");

    free_step_a: assert property (
        state_q == EQS_SEARCH && cnt_q == '0 && !cdr_lock && !restart_p && gain_q != EQS_GAIN_MAX
        |=> gain_q == $past(gain_q) + 4'h1)
        else $error("search did not advance");

    restart_load_a: assert property (
        restart_p |=> state_q == EQS_SEARCH && gain_q == $past(start_gain))
        else $error("restart did not reload start gain");

    floor_apply_a: assert property (
        restart_p && !(ctl1_d.floor_override_enable && ctl1_d.floor_apply_enable) |=> gain_q == EQS_GAIN_MIN)
        else $error("floor used without both enables");

    floor_start_a: assert property (
        restart_p && ctl1_d.floor_override_enable && ctl1_d.floor_apply_enable
        |=> gain_q == $past(ctl2_d.gain_search_floor_level))
        else $error("pass did not start at floor");

    status_read_a: assert property (
        reg_rd && reg_addr == EQS_STAT_ADDR |=> reg_rdata[3:0] == $past(gain_q) && reg_rdata[7:5] == 3'h0)
        else $error("status readback wrong");

    dwell_len_a: assert property (
        restart_p && ctl2_q.relock_dwell_time == 3'h0 ##1 !restart_p [*2]
        |-> cnt_q == EQS_CNT_W'(DWELL_UNIT_CYC - 1))
        else $error("dwell length wrong");

    wrap_a: assert property (
        state_q == EQS_SEARCH && cnt_q == '0 && !cdr_lock && !restart_p && gain_q == EQS_GAIN_MAX
        |=> gain_q == $past(start_gain))
        else $error("no wrap at maximum");

    reload_a: assert property (
        $changed(gain_q) |-> cnt_q == $past(dwell_cyc))
        else $error("dwell counter not reloaded");

    stall_bound_a: assert property (
        stall_q <= EQS_CNT_W'(8 * DWELL_UNIT_CYC + 1))
        else $error("search stalled on one setting");

    lock_check_a: assert property (
        state_q == EQS_SEARCH && cnt_q == '0 && cdr_lock && !restart_p |=> eq_locked && $stable(gain_q))
        else $error("lock not taken after dwell");

    early_lock_a: assert property (
        state_q == EQS_SEARCH && cnt_q != '0 |=> !eq_locked)
        else $error("hold entered before dwell ended");

    ceiling_a: assert property (
        state_q == EQS_SEARCH && gain_q == EQS_GAIN_MAX && !restart_p
        |=> gain_q == EQS_GAIN_MAX || gain_q == $past(start_gain))
        else $error("gain went past the fixed ceiling");

    restart_cnt_a: assert property (
        restart_p |=> cnt_q == $past(dwell_cyc))
        else $error("dwell counter not reloaded on restart");

    restart_unlock_a: assert property (
        restart_p && state_q == EQS_HOLD |=> !eq_locked)
        else $error("restart ignored while holding");

    // register port checks
    ctl1_store_a: assert property (
        reg_wr && reg_addr == EQS_CTL1_ADDR |=> ctl1_q.floor_override_enable == $past(reg_wdata[1])
        && ctl1_q.floor_apply_enable == $past(reg_wdata[2]) && !ctl1_q.equalizer_search_restart)
        else $error("primary control not stored");

    ctl2_store_a: assert property (
        reg_wr && reg_addr == EQS_CTL2_ADDR |=> ctl2_q.gain_search_floor_level == $past(reg_wdata[7:4])
        && ctl2_q.relock_dwell_time == $past(reg_wdata[2:0]))
        else $error("secondary control not stored");

    ctl_read_a: assert property (
        reg_rd && reg_addr == EQS_CTL1_ADDR
        |=> reg_rdata[0] == 1'b0 && reg_rdata[2:1] == $past({ctl1_q.floor_apply_enable, ctl1_q.floor_override_enable}))
        else $error("primary control readback wrong");

    rdata_idle_a: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not cleared when idle");

    unmapped_read_a: assert property (
        reg_rd && reg_addr != EQS_CTL1_ADDR && reg_addr != EQS_CTL2_ADDR && reg_addr != EQS_STAT_ADDR
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    status_lock_a: assert property (
        reg_rd && reg_addr == EQS_STAT_ADDR |=> reg_rdata[4] == $past(eq_locked))
        else $error("status lock bit wrong");

    // covers of the main scenarios
    lock_found_c: cover property (state_q == EQS_SEARCH ##1 state_q == EQS_HOLD);
    lock_lost_c: cover property (state_q == EQS_HOLD ##1 state_q == EQS_SEARCH);
    wrap_c: cover property (gain_q == EQS_GAIN_MAX ##1 gain_q == EQS_GAIN_MIN);
    restart_c: cover property (restart_p && state_q == EQS_HOLD);
    floor_start_c: cover property (restart_p && ctl1_d.floor_override_enable && ctl1_d.floor_apply_enable);

endmodule

// File: eqs_pkg.sv
// eqs_pkg: register map, field layouts, reset values and timing for the
// receive equalizer search controller.
// assumes a single 50 MHz system clock and byte-wide register access.
package eqs_pkg;

    // register offsets
    localparam logic [7:0] EQS_CTL1_ADDR = 8'h35;
    localparam logic [7:0] EQS_STAT_ADDR = 8'h3B;
    localparam logic [7:0] EQS_CTL2_ADDR = 8'h45;

    // gain code width; the top code is the fixed search ceiling
    localparam int EQS_GAIN_W = 4;
    localparam logic [3:0] EQS_GAIN_MIN = 4'h0;
    localparam logic [3:0] EQS_GAIN_MAX = 4'hF;

    // primary control: bit0 restart (self clearing), bit1 override, bit2 apply
    typedef struct packed {
        logic [4:0] rsvd;
        logic floor_apply_enable;
        logic floor_override_enable;
        logic equalizer_search_restart;
    } eqs_ctl1_t;

    // secondary control: [7:4] floor level, [3] reserved, [2:0] dwell code
    typedef struct packed {
        logic [3:0] gain_search_floor_level;
        logic rsvd;
        logic [2:0] relock_dwell_time;
    } eqs_ctl2_t;

    // readback: [4] held on lock, [3:0] current gain code
    typedef struct packed {
        logic [2:0] rsvd;
        logic locked;
        logic [3:0] gain;
    } eqs_stat_t;

    localparam logic [7:0] EQS_CTL1_RST = 8'h00;
    localparam logic [7:0] EQS_CTL2_RST = 8'h03;

    // dwell time is (code + 1) units; default code gives 2.62 ms
    localparam int EQS_CLK_NS = 20;
    localparam int EQS_DWELL_DEF_NS = 2620000;
    localparam int EQS_DWELL_DEF_CODE = 3;
    localparam int EQS_DWELL_UNIT_NS = EQS_DWELL_DEF_NS / (EQS_DWELL_DEF_CODE + 1);
    localparam int EQS_DWELL_UNIT_CYC = EQS_DWELL_UNIT_NS / EQS_CLK_NS;
    localparam int EQS_CNT_W = 20;

    typedef enum logic [0:0] {
        EQS_SEARCH,
        EQS_HOLD
    } eqs_state_t;

endpackage

// File: eqs_cdr_model.sv
// eqs_cdr_model: lock detector of the receive port, seen by the search.
// assumes its controls are driven synchronously to clk_sys.
`timescale 1ns/1ps
module eqs_cdr_model
    import eqs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [EQS_GAIN_W-1:0] eq_gain,
    input wire logic [EQS_GAIN_W-1:0] good_gain,
    input wire logic good_en,
    input wire logic [1:0] lag,
    output logic cdr_lock
);
    logic [1:0] run_q;
    logic [1:0] run_d;
    // cycles spent on the good code; lag makes lock slow to appear
    always_comb begin
        run_d = run_q;
        if (!good_en || eq_gain != good_gain) begin
            run_d = 2'h0;
        end else if (run_q != 2'h3) begin
            run_d = run_q + 2'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            run_q <= 2'h0;
        end else begin
            run_q <= run_d;
        end
    end
    assign cdr_lock = good_en && eq_gain == good_gain && run_q >= lag;
endmodule

// File: eqs_search_ctrl_tb.sv
// eqs_search_ctrl_tb: self-checking bench for the equalizer search.
// assumes a 50 MHz clock and a short dwell unit of 4 cycles.
`timescale 1ns/1ps
module eqs_search_ctrl_tb;
    import eqs_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic digital_soft_reset = 1'b0;
    logic cdr_lock;
    logic [3:0] eq_gain;
    logic eq_locked;
    logic [3:0] good_gain = 4'h0;
    logic good_en = 1'b0;
    logic [1:0] lag = 2'h0;
    logic [7:0] exp_q[$];
    logic rd_seen = 1'b0;
    logic [31:0] seed = 32'h0000002C;
    logic [3:0] nxt;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    int n;
    eqs_search_ctrl #(.DWELL_UNIT_CYC(4)) i_eqs_search_ctrl (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .digital_soft_reset(digital_soft_reset), .cdr_lock(cdr_lock), .eq_gain(eq_gain), .eq_locked(eq_locked));
    eqs_cdr_model i_eqs_cdr_model (.clk_sys(clk_sys), .arst_n(arst_n), .eq_gain(eq_gain),
        .good_gain(good_gain), .good_en(good_en), .lag(lag), .cdr_lock(cdr_lock));
    initial forever #10 clk_sys = ~clk_sys;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            err_total++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        exp_q.push_back(want);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask
    // cycles until the gain code moves off its present value
    task automatic wait_chg(input logic [3:0] g);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (eq_gain === g && n < 300);
    endtask
    task automatic wait_lk();
        n = 0;
        while (eq_locked !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    // read data monitor and run limit
    always @(posedge clk_sys) begin
        cyc++;
        if (rd_seen) check(reg_rdata, exp_q.pop_front());
        rd_seen <= reg_rd;
        if (cyc == 6000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(EQS_CTL1_ADDR, EQS_CTL1_RST);
        rd(EQS_CTL2_ADDR, EQS_CTL2_RST);
        rd(8'h10, 8'h00);
        wait_chg(4'h0);
        check({4'h0, eq_gain}, 8'h01);
        // dwell per setting for the shortest and longest code
        for (int c = 0; c < 8; c += 7) begin
            wr(EQS_CTL2_ADDR, 8'(c));
            wr(EQS_CTL1_ADDR, 8'h01);
            wait_chg(eq_gain);
            wait_chg(eq_gain);
            check(8'(n), 8'((c + 1) * 4 + 1));
        end
        wr(EQS_CTL2_ADDR, 8'h5B);
        rd(EQS_CTL2_ADDR, 8'h5B);
        wr(EQS_CTL2_ADDR, 8'h53);
        // floor start only with override and apply together
        for (int v = 3; v < 8; v += 2) begin
            wr(EQS_CTL1_ADDR, 8'(v));
            rd(EQS_STAT_ADDR, (v == 7) ? 8'h05 : 8'h00);
            rd(EQS_CTL1_ADDR, 8'(v - 1));
        end
        n = 0;
        while (eq_gain !== 4'hF && n < 600) begin
            @(posedge clk_sys);
            n++;
        end
        wait_chg(4'hF);
        check({4'h0, eq_gain}, 8'h05);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            good_gain <= 4'h6 + 4'(seed[7:0] % 10);
            lag <= seed[9:8];
            good_en <= 1'b1;
            wait_lk();
            check({7'h00, eq_locked}, 8'h01);
            rd(EQS_STAT_ADDR, {4'h1, good_gain});
            repeat (40) @(posedge clk_sys);
            rd(EQS_STAT_ADDR, {4'h1, good_gain});
            nxt = (good_gain == 4'hF) ? 4'h5 : good_gain + 4'h1;
            good_en <= 1'b0;
            rd(EQS_STAT_ADDR, {4'h0, nxt});
            good_en <= 1'b1;
            wait_lk();
            if (k[0]) begin
                @(posedge clk_sys);
                digital_soft_reset <= 1'b1;
                @(posedge clk_sys);
                digital_soft_reset <= 1'b0;
            end else begin
                wr(EQS_CTL1_ADDR, 8'h07);
            end
            rd(EQS_STAT_ADDR, 8'h05);
        end
        tally_and_finish();
    end
endmodule
